// ===== pkg/cic_pkg.sv
// Package of register indices, field positions and reset values for the interrupt control block.
package cic_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [9:0] IDX_CONTROL     = 10'h00b;
	localparam logic [9:0] IDX_PFLAG_1     = 10'h011;
	localparam logic [9:0] IDX_PFLAG_2     = 10'h012;
	localparam logic [9:0] IDX_PFLAG_3     = 10'h013;
	localparam logic [9:0] IDX_PFLAG_4     = 10'h014;
	localparam logic [9:0] IDX_PENABLE_1   = 10'h020;
	localparam logic [9:0] IDX_PENABLE_2   = 10'h021;
	localparam logic [9:0] IDX_PENABLE_3   = 10'h022;
	localparam logic [9:0] IDX_PENABLE_4   = 10'h023;
	localparam logic [9:0] IDX_PIN_FLAGS   = 10'h024;
	localparam logic [9:0] IDX_EVT_STATUS  = 10'h025;
	localparam logic [9:0] IDX_EVT_MASK    = 10'h026;

	// Bus geometry.
	localparam int APB_ADDR_W = 12;

	// Field positions inside the control register.
	localparam int BIT_GLOBAL_EN = 7;
	localparam int BIT_PERIPH_EN = 6;
	localparam int BIT_T0IE    = 5;
	localparam int BIT_EXTIE   = 4;
	localparam int BIT_PINIE   = 3;
	localparam int BIT_T0FLAG  = 2;
	localparam int BIT_EXTFLAG = 1;
	localparam int BIT_PINSUM  = 0;

	// Event status bit positions.
	localparam int EVT_TIMER  = 0;
	localparam int EVT_EXT    = 1;
	localparam int EVT_PIN    = 2;
	localparam int EVT_PERIPH = 3;

	// Values after reset.
	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic [7:0] FLAG_RESET     = 8'h00;
	localparam logic [7:0] PENABLE_RESET  = 8'h00;
	localparam logic [7:0] EVT_MASK_RESET = 8'h00;

	// Implemented bits of each register; the others read as zero.
	localparam logic [3:0][7:0] PFLAG_IMPL = {8'h03, 8'h3a, 8'hf9, 8'hff};
	localparam logic [7:0]      PIN_IMPL   = 8'hff;
	localparam logic [7:0]      EVT_IMPL   = 8'h0f;

endpackage

// ===== pkg/cic_flag_if.sv
// Interface carrying one byte of hardware-set flags between the control logic and a flag register.
`timescale 1ns/1ps
`default_nettype none

interface cic_flag_if;
	logic       wr;
	logic [7:0] wdata;
	logic [7:0] set;
	logic [7:0] value;

	modport owner (input wr, input wdata, input set, output value);
	modport user  (output wr, output wdata, output set, input value);
endinterface

`default_nettype wire

// ===== logic/cic_flag_reg.sv
// One byte of sticky flags set by hardware and written or cleared by software.
`timescale 1ns/1ps
`default_nettype none

module cic_flag_reg
	import cic_pkg::*;
#(
	parameter logic [7:0] IMPL  = 8'hff,
	parameter logic [7:0] RESET = 8'h00,
	parameter bit         W1C   = 1'b0
) (
	input  wire logic clk,
	input  wire logic reset_n,
	cic_flag_if.owner f
);

	typedef struct packed {
		logic [7:0] value;
	} cic_flag_s;

	cic_flag_s st;
	cic_flag_s next_st;

	// The hardware set is applied after the software write so an event in the clear cycle wins.
	always_comb begin
		next_st = st;
		if (f.wr) begin
			next_st.value = W1C ? (st.value & ~f.wdata) : f.wdata;
		end
		next_st.value = (next_st.value | f.set) & IMPL;
	end

	// Synchronous reset to the register's reset value.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st.value <= RESET;
		end else begin
			st <= next_st;
		end
	end

	assign f.value = st.value;

endmodule

`default_nettype wire

// ===== logic/cic_top.sv
// Interrupt control block: control register, peripheral flags and enables, and core request.
//
// What this block does
// - Global enable bit 7 lets active interrupts through to irq_to_core when one, blocks all of them there when zero; irq does not depend on it.
// - Peripheral enable bit 6 passes peripheral interrupts to irq_to_core when one, suppresses them there when zero.
// - Control bit 5 enables the timer zero overflow interrupt.
// - Control bit 4 enables the external pin interrupt.
// - Control bit 3 enables the pin change interrupt.
// - Bit 2 is set when the timer zero count overflows.
// - Bit 1 is set when an external pin interrupt event occurs.
// - Bit 0 reads one while any per-pin change flag is set.
// - The summary flag is read-only and clears once software clears every per-pin flag.
// - Flags set on their event regardless of their own or the global enable.
// - Every bit of the control register resets to zero on any reset.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module cic_top
	import cic_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [APB_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	input  wire logic                  timer_zero_overflow,
	input  wire logic                  ext_pin_event,
	input  wire logic [7:0]            pin_change_events,
	input  wire logic [31:0]           periph_events,
	output var  logic                  irq_to_core,
	output var  logic                  irq
);

	// Whole register state of the top level.
	typedef struct packed {
		logic [7:3]      en;
		logic            t0_flag;
		logic            ext_flag;
		logic [3:0][7:0] pen;
		logic [7:0]      evt_mask;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
		logic            irq_core;
		logic            irq;
	} cic_top_s;

	cic_top_s st;
	cic_top_s next_st;

	// Six flag bytes: four peripheral flag registers, the per-pin change flags and event status.
	localparam int N_FLAG = 6;
	localparam int FL_PIN = 4;
	localparam int FL_EVT = 5;

	cic_flag_if fl[N_FLAG] ();
	logic [7:0] fval [N_FLAG];

	logic [9:0] idx;
	logic       aligned;
	logic       access;
	logic       wr_en;
	logic       byte0_wr;
	logic       mapped;
	logic [7:0] ctrl_val;
	logic       pin_sum;
	logic       periph_any;
	logic [3:0] periph_pend;
	logic       core_pend;
	logic [7:0] rd_byte;

	// Bus decode; a write takes effect only at the edge that completes the access phase.
	assign idx      = paddr[APB_ADDR_W-1:2];
	assign aligned  = (paddr[1:0] == 2'b00);
	assign access   = psel && penable;
	assign wr_en    = access && st.pready && pwrite && aligned;
	assign byte0_wr = wr_en && pstrb[0];

	// Summary of per-pin change flags; it falls only after software clears all of them.
	assign pin_sum  = |fval[FL_PIN];

	// The readable control byte; bit 0 is the summary and ignores writes.
	assign ctrl_val = {st.en, st.t0_flag, st.ext_flag, pin_sum};

	// Peripheral event inputs restricted to implemented flag bits.
	assign periph_any = |(periph_events & PFLAG_IMPL);

	// Peripheral flag registers and their write strobes.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pflag
			assign fl[gi].wr    = byte0_wr && (idx == IDX_PFLAG_1 + 10'(gi));
			assign fl[gi].wdata = pwdata[7:0];
			assign fl[gi].set   = periph_events[gi*8 +: 8];
			assign fval[gi]     = fl[gi].value;
			assign periph_pend[gi] = |(fl[gi].value & st.pen[gi]);

			cic_flag_reg #(
				.IMPL  (PFLAG_IMPL[gi]),
				.RESET (FLAG_RESET),
				.W1C   (1'b0)
			) u_pflag (
				.clk     (clk),
				.reset_n (reset_n),
				.f       (fl[gi].owner)
			);
		end
	endgenerate

	// Per-pin change flags: software writes zeros to clear, a new change still sets.
	assign fl[FL_PIN].wr    = byte0_wr && (idx == IDX_PIN_FLAGS);
	assign fl[FL_PIN].wdata = pwdata[7:0];
	assign fl[FL_PIN].set   = pin_change_events;
	assign fval[FL_PIN]     = fl[FL_PIN].value;

	cic_flag_reg #(
		.IMPL  (PIN_IMPL),
		.RESET (FLAG_RESET),
		.W1C   (1'b0)
	) u_pin_flags (
		.clk     (clk),
		.reset_n (reset_n),
		.f       (fl[FL_PIN].owner)
	);

	// Event status for the system interrupt: sticky, cleared by writing ones.
	assign fl[FL_EVT].wr    = byte0_wr && (idx == IDX_EVT_STATUS);
	assign fl[FL_EVT].wdata = pwdata[7:0];
	assign fl[FL_EVT].set   = {4'h0, periph_any, |pin_change_events,
		ext_pin_event, timer_zero_overflow};
	assign fval[FL_EVT]     = fl[FL_EVT].value;

	cic_flag_reg #(
		.IMPL  (EVT_IMPL),
		.RESET (FLAG_RESET),
		.W1C   (1'b1)
	) u_evt_status (
		.clk     (clk),
		.reset_n (reset_n),
		.f       (fl[FL_EVT].owner)
	);

	// Pending sources after their own enables; the global gate is applied below.
	assign core_pend = (st.en[BIT_T0IE] && st.t0_flag)
		|| (st.en[BIT_EXTIE] && st.ext_flag)
		|| (st.en[BIT_PINIE] && pin_sum);

	// Read multiplexer and address map; anything else answers with an error.
	always_comb begin
		rd_byte = 8'h00;
		mapped  = aligned;
		case (idx)
			IDX_CONTROL:    rd_byte = ctrl_val;
			IDX_PFLAG_1:    rd_byte = fval[0];
			IDX_PFLAG_2:    rd_byte = fval[1];
			IDX_PFLAG_3:    rd_byte = fval[2];
			IDX_PFLAG_4:    rd_byte = fval[3];
			IDX_PENABLE_1:  rd_byte = st.pen[0];
			IDX_PENABLE_2:  rd_byte = st.pen[1] & PFLAG_IMPL[1];
			IDX_PENABLE_3:  rd_byte = st.pen[2] & PFLAG_IMPL[2];
			IDX_PENABLE_4:  rd_byte = st.pen[3] & PFLAG_IMPL[3];
			IDX_PIN_FLAGS:  rd_byte = fval[FL_PIN];
			IDX_EVT_STATUS: rd_byte = fval[FL_EVT];
			IDX_EVT_MASK:   rd_byte = st.evt_mask;
			default:        mapped  = 1'b0;
		endcase
	end

	// Next state of the top level.
	always_comb begin
		next_st = st;

		// One wait state: pready rises in the second access cycle, read data with it.
		next_st.pready  = access && !st.pready;
		next_st.pslverr = access && !st.pready && !mapped;
		if (access && !st.pready) begin
			next_st.prdata = (mapped && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
		end

		// Control register write: enables take the written value.
		if (byte0_wr && idx == IDX_CONTROL) begin
			next_st.en       = pwdata[7:3];
			next_st.t0_flag  = pwdata[BIT_T0FLAG];
			next_st.ext_flag = pwdata[BIT_EXTFLAG];
		end

		// Hardware sets after the write, so an event in a clearing cycle is kept.
		if (timer_zero_overflow) begin
			next_st.t0_flag = 1'b1;
		end
		if (ext_pin_event) begin
			next_st.ext_flag = 1'b1;
		end

		// Peripheral enable registers, one byte each.
		for (int k = 0; k < 4; k++) begin
			if (byte0_wr && idx == IDX_PENABLE_1 + 10'(k)) begin
				next_st.pen[k] = pwdata[7:0] & PFLAG_IMPL[k];
			end
		end

		if (byte0_wr && idx == IDX_EVT_MASK) begin
			next_st.evt_mask = pwdata[7:0] & EVT_IMPL;
		end

		// Core request: peripherals need their own enable, and everything needs the global one.
		next_st.irq_core = st.en[BIT_GLOBAL_EN]
			&& (core_pend || (st.en[BIT_PERIPH_EN] && (|periph_pend)));

		// System interrupt line: high while an unmasked status bit is set.
		next_st.irq = |(fval[FL_EVT] & st.evt_mask);
	end

	// State register with synchronous reset; every control bit clears on any reset.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st.en       <= CONTROL_RESET[7:3];
			st.t0_flag  <= CONTROL_RESET[BIT_T0FLAG];
			st.ext_flag <= CONTROL_RESET[BIT_EXTFLAG];
			st.pen      <= {4{PENABLE_RESET}};
			st.evt_mask <= EVT_MASK_RESET;
			st.pready   <= 1'b0;
			st.pslverr  <= 1'b0;
			st.prdata   <= 32'h00000000;
			st.irq_core <= 1'b0;
			st.irq      <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flip-flops.
	assign prdata      = st.prdata;
	assign pready      = st.pready;
	assign pslverr     = st.pslverr;
	assign irq_to_core = st.irq_core;
	assign irq         = st.irq;

endmodule

`default_nettype wire

// ===== sim/cic_checker.sv
// Assertion checker bound to the interrupt control block ports.
`timescale 1ns/1ps
`default_nettype none
module cic_checker
	import cic_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [3:0]            pstrb,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  timer_zero_overflow,
	input wire logic                  ext_pin_event,
	input wire logic [7:0]            pin_change_events,
	input wire logic                  irq_to_core
);
	logic [7:3] en;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Shadow of the enable bits, so request timing can be judged from the bus alone.
	always_ff @(posedge clk) begin
		if (!reset_n)
			en <= 5'h00;
		else if (psel && penable && pready && pwrite && pstrb[0]
			&& paddr == {IDX_CONTROL, 2'b00})
			en <= pwdata[7:3];
	end
	sequence s_tmr; timer_zero_overflow ##1 (en[7] && en[5]); endsequence
	sequence s_ext; ext_pin_event ##1 (en[7] && en[4]); endsequence
	sequence s_pin; (|pin_change_events) ##1 (en[7] && en[3]); endsequence
	AST_RDY_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	AST_RDY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_ERR_ALIGN: assert property (psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access not refused");
	AST_GLOBAL_OFF: assert property (!en[7] |=> !irq_to_core)
		else $error("core request while globally disabled");
	AST_EN_OFF: assert property (en[6:3] == 4'h0 |=> !irq_to_core)
		else $error("core request with every source disabled");
	AST_TMR_IRQ: assert property (s_tmr |=> irq_to_core)
		else $error("timer overflow did not request");
	AST_EXT_IRQ: assert property (s_ext |=> irq_to_core)
		else $error("external event did not request");
	AST_PIN_IRQ: assert property (s_pin |=> irq_to_core)
		else $error("pin change did not request");
endmodule
bind cic_top cic_checker cic_checker_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .pready, .pslverr, .timer_zero_overflow, .ext_pin_event,
	.pin_change_events, .irq_to_core);
`default_nettype wire

// ===== sim/cic_src.sv
// Model of the timer, pin and peripheral event sources.
`timescale 1ns/1ps
`default_nettype none
module cic_src (
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic [1:0]  kind,
	input  wire logic [31:0] val,
	output var  logic        timer_zero_overflow,
	output var  logic        ext_pin_event,
	output var  logic [7:0]  pin_change_events,
	output var  logic [31:0] periph_events
);
	// Each request gives a pulse of one cycle, so no flag is set twice by one event.
	always @(posedge clk) begin
		timer_zero_overflow <= go && kind == 2'd0;
		ext_pin_event <= go && kind == 2'd1;
		pin_change_events <= (go && kind == 2'd2) ? val[7:0] : 8'h00;
		periph_events <= (go && kind == 2'd3) ? val : 32'h0;
	end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the interrupt control block.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import cic_pkg::*;
;
	logic        clk, reset_n, psel, penable, pwrite, go, er;
	logic        pready, pslverr, irq_to_core, irq, timer_zero_overflow, ext_pin_event;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, periph_events, val, seed = 32'h9f5f;
	logic [7:0]  pin_change_events, rd;
	logic [3:0]  pstrb = 4'h1;
	logic [1:0]  kind;
	int          err_total, checks_done, m_c, m_pin, m_st, m_mk, m_pf[4], m_pe[4];
	cic_top cic_top_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .timer_zero_overflow, .ext_pin_event,
		.pin_change_events, .periph_events, .irq_to_core, .irq);
	cic_src cic_src_i (.clk, .go, .kind, .val, .timer_zero_overflow, .ext_pin_event,
		.pin_change_events, .periph_events);
	// Free-running clock of 10 ns.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected core request from the model registers.
	function automatic logic core();
		int p;
		p = 0;
		for (int i = 0; i < 4; i++) p |= m_pf[i] & m_pe[i];
		return m_c[7] && (m_c[5] && m_c[2] || m_c[4] && m_c[1] || m_c[3] && m_pin != 0
			|| m_c[6] && p != 0);
	endfunction
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %0t data %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %0t bit %b expected %b", $time, g, e);
		end
	endtask
	// One bus transfer; the request is held until ready is seen at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wrc(input logic [9:0] i, input logic [7:0] d);
		apb(1'b1, {i, 2'b00}, d);
	endtask
	task automatic rdc(input logic [9:0] i);
		apb(1'b0, {i, 2'b00}, 8'h00);
	endtask
	// One event pulse through the source model; unimplemented peripheral bits are sent too.
	task automatic fire(input logic [1:0] t, input logic [31:0] v);
		logic [31:0] pv;
		pv = v & PFLAG_IMPL;
		@(posedge clk);
		{go, kind, val} <= {1'b1, t, v};
		@(posedge clk);
		go <= 1'b0;
		if (t == 2'd0) begin
			m_c |= 4;
			m_st |= 1;
		end
		if (t == 2'd1) begin
			m_c |= 2;
			m_st |= 2;
		end
		if (t == 2'd2 && v[7:0] != 8'h00) begin
			m_pin |= v[7:0];
			m_st |= 4;
		end
		if (t == 2'd3) begin
			for (int i = 0; i < 4; i++) begin
				m_pf[i] |= pv[8*i +: 8];
			end
			if (pv != 0) m_st |= 8;
		end
	endtask
	// One random operation, then the model is compared with the design.
	task automatic step();
		logic [31:0] r, v;
		int k;
		r = xs();
		v = xs();
		k = r[17:16];
		case (r % 6)
			0: begin wrc(IDX_CONTROL, v[7:0]); m_c = v & 8'hfe; end
			1: fire(r[4:3], v);
			2: begin wrc(IDX_PFLAG_1 + 10'(k), v[7:0]); m_pf[k] = v[7:0] & PFLAG_IMPL[k]; end
			3: begin wrc(IDX_PENABLE_1 + 10'(k), v[7:0]); m_pe[k] = v[7:0] & PFLAG_IMPL[k]; end
			4: begin wrc(IDX_PIN_FLAGS, v[7:0] & m_pin[7:0]); m_pin &= v[7:0]; end
			default: if (r[9]) begin wrc(IDX_EVT_MASK, v[7:0]); m_mk = v & 15; end
				else begin wrc(IDX_EVT_STATUS, v[7:0]); m_st &= ~v; end
		endcase
		rdc(IDX_CONTROL);
		chk8(rd, 8'((m_c & 8'hfe) | (m_pin != 0)));
		chk1(er, 1'b0);
		rdc(IDX_PFLAG_1 + 10'(k));
		chk8(rd, 8'(m_pf[k]));
		chk1(irq_to_core, core());
		chk1(irq, (m_st & m_mk) != 0);
	endtask
	// Main sequence: reset values, refusals, random traffic, reset in mid-run.
	initial begin
		{reset_n, psel, penable, pwrite, go, kind, paddr, pwdata, val} = '0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			rdc(k ? IDX_PFLAG_1 + 10'(k - 1) : IDX_CONTROL);
			chk8(rd, 8'h00);
		end
		apb(1'b0, 12'h02d, 8'h00);
		chk1(er, 1'b1);
		chk8(rd, 8'h00);
		apb(1'b0, 12'hffc, 8'h00);
		chk1(er, 1'b1);
		// A write with its byte strobe low must leave the register alone.
		pstrb <= 4'h0;
		wrc(IDX_EVT_MASK, 8'h0f);
		pstrb <= 4'h1;
		rdc(IDX_EVT_MASK);
		chk8(rd, 8'(m_mk));
		// Software clears a pending timer flag before enabling it, so no stale request follows.
		fire(2'd0, 32'h0);
		wrc(IDX_CONTROL, 8'h00);
		m_c = 0;
		wrc(IDX_CONTROL, 8'ha0);
		m_c = 8'ha0;
		rdc(IDX_CONTROL);
		chk8(rd, 8'(m_c));
		chk1(irq_to_core, core());
		repeat (300) step();
		wrc(IDX_CONTROL, 8'hfe);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rdc(IDX_CONTROL);
		chk8(rd, 8'h00);
		chk1(irq_to_core, 1'b0);
		chk1(irq, 1'b0);
		// The model restarts from reset values, then traffic resumes.
		m_c = 0;
		m_pin = 0;
		m_st = 0;
		m_mk = 0;
		for (int i = 0; i < 4; i++) begin
			m_pf[i] = 0;
			m_pe[i] = 0;
		end
		repeat (20) step();
		conclude();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
